// ==== core/pcr_pkg.sv ====
// Constants shared by the PCS control register block
package pcr_pkg;

    // ------------------------------------------------------------------
    // Register map and field positions
    // ------------------------------------------------------------------
    localparam logic [4:0] CTRL_REG_ADDR  = 5'h00;
    localparam logic [4:0] BCAST_PHY_ADDR = 5'h00;
    localparam int         BIT_RESET      = 15;
    localparam int         BIT_LOOPBACK   = 14;
    localparam int         BIT_SPEED_LSB  = 13;
    localparam int         BIT_AN_ENABLE  = 12;
    localparam int         BIT_POWER_DOWN = 11;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic LOOPBACK_DEF   = 1'b0;
    localparam logic SPEED_LSB_DEF  = 1'b0;
    localparam logic AN_ENABLE_DEF  = 1'b1;
    localparam logic POWER_DOWN_DEF = 1'b0;

    // ------------------------------------------------------------------
    // Management frame encodings and field lengths
    // ------------------------------------------------------------------
    localparam logic [1:0] OP_WRITE  = 2'h1;
    localparam logic [1:0] OP_READ   = 2'h2;
    localparam logic [4:0] HDR_LAST  = 5'h0b;
    localparam logic [4:0] TA_LAST   = 5'h01;
    localparam logic [4:0] DATA_LAST = 5'h0f;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS   = 4000;
    localparam int SOFT_RST_MIN_NS = 16;
    localparam int SOFT_RST_CYCLES =
        (SOFT_RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

// ==== core/pcr_mgmt_if.sv ====
// Register access strobes between the management frame engine and the bank
`timescale 1ns/1ps
interface pcr_mgmt_if;
    logic        wr_stb;
    logic        rd_stb;
    logic [4:0]  reg_addr;
    logic [15:0] wr_data;
    logic [15:0] rd_data;

    modport engine (output wr_stb, output rd_stb, output reg_addr, output wr_data,
                    input rd_data);
    modport bank   (input wr_stb, input rd_stb, input reg_addr, input wr_data,
                    output rd_data);
endinterface

// ==== core/pcr_ctrl_bank.sv ====
// Control register bank: bits 15 to 11, core reset sequencing, outputs
`timescale 1ns/1ps
module pcr_ctrl_bank (
    input  wire logic   ref_clk,
    input  wire logic   nrst,
    pcr_mgmt_if.bank    mgmt,
    input  wire logic   ext_reset_sync,
    input  wire logic   lock_sync,
    input  wire logic   tbi_mode,
    input  wire logic   sgmii_mode,
    input  wire logic   pgc_mode,
    input  wire logic   an_present,
    input  wire logic   on_chip_xcvr,
    input  wire logic   pma_present,
    input  wire logic   rx_client_clock_source,
    input  wire logic   cfg_load,
    input  wire logic [4:0] cfg_vector,
    output logic        core_reset,
    output logic        loopback_internal,
    output logic        wrap_out,
    output logic        speed_lsb,
    output logic        an_enable,
    output logic        power_down_xcvr
);

    logic       lb_r, lb_nxt;
    logic       spd_r, spd_nxt;
    logic       an_r, an_nxt;
    logic       pd_r, pd_nxt;
    logic [2:0] srst_cnt_r, srst_cnt_nxt;
    logic       srst_active;
    logic       core_rst;
    logic       spd_writable;
    logic       wr_any;
    logic [4:0] wr_bits;
    logic [5:0] out_r, out_nxt;

    // ------------------------------------------------------------------
    // Reset sources and write selection
    // ------------------------------------------------------------------
    assign srst_active  = (srst_cnt_r != 3'h0);
    assign core_rst     = ext_reset_sync | ~lock_sync | srst_active;
    assign spd_writable = sgmii_mode & pgc_mode;
    // A management write beats a configuration vector load in the same cycle
    assign wr_any  = (mgmt.wr_stb && mgmt.reg_addr == pcr_pkg::CTRL_REG_ADDR) | cfg_load;
    assign wr_bits = (mgmt.wr_stb && mgmt.reg_addr == pcr_pkg::CTRL_REG_ADDR) ?
                     mgmt.wr_data[15:11] : cfg_vector;

    // Next values of the stored control bits
    always_comb begin
        lb_nxt       = lb_r;
        spd_nxt      = spd_r;
        an_nxt       = an_r;
        pd_nxt       = pd_r;
        srst_cnt_nxt = srst_active ? srst_cnt_r - 3'h1 : 3'h0;
        if (core_rst) begin
            lb_nxt  = pcr_pkg::LOOPBACK_DEF;
            spd_nxt = pcr_pkg::SPEED_LSB_DEF;
            an_nxt  = pcr_pkg::AN_ENABLE_DEF;
            pd_nxt  = pcr_pkg::POWER_DOWN_DEF;
        end else if (wr_any) begin
            if (wr_bits[pcr_pkg::BIT_RESET - 11]) begin
                // Other bits of this write would be wiped anyway, so skip them
                srst_cnt_nxt = 3'(pcr_pkg::SOFT_RST_CYCLES);
            end else begin
                lb_nxt  = wr_bits[pcr_pkg::BIT_LOOPBACK - 11];
                spd_nxt = spd_writable & wr_bits[pcr_pkg::BIT_SPEED_LSB - 11];
                an_nxt  = wr_bits[pcr_pkg::BIT_AN_ENABLE - 11];
                // Writing 0 cannot clear power down; only a core reset does
                pd_nxt  = pd_r | wr_bits[pcr_pkg::BIT_POWER_DOWN - 11];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lb_r       <= pcr_pkg::LOOPBACK_DEF;
            spd_r      <= pcr_pkg::SPEED_LSB_DEF;
            an_r       <= pcr_pkg::AN_ENABLE_DEF;
            pd_r       <= pcr_pkg::POWER_DOWN_DEF;
            srst_cnt_r <= 3'h0;
        end else begin
            lb_r       <= lb_nxt;
            spd_r      <= spd_nxt;
            an_r       <= an_nxt;
            pd_r       <= pd_nxt;
            srst_cnt_r <= srst_cnt_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Read word; the reset bit shows 1 only while the soft reset runs
    // ------------------------------------------------------------------
    always_comb begin
        mgmt.rd_data = 16'h0000;
        if (mgmt.reg_addr == pcr_pkg::CTRL_REG_ADDR) begin
            mgmt.rd_data[pcr_pkg::BIT_RESET]      = srst_active;
            mgmt.rd_data[pcr_pkg::BIT_LOOPBACK]   = lb_r;
            mgmt.rd_data[pcr_pkg::BIT_SPEED_LSB]  = spd_r & spd_writable;
            mgmt.rd_data[pcr_pkg::BIT_AN_ENABLE]  = an_r & an_present;
            mgmt.rd_data[pcr_pkg::BIT_POWER_DOWN] = pd_r;
        end
    end

    // Registered control outputs toward the datapath and transceiver
    always_comb begin
        out_nxt[0] = core_rst;
        // No internal loopback when the client clock is the recovered clock
        out_nxt[1] = lb_r & on_chip_xcvr & ~tbi_mode & ~rx_client_clock_source;
        out_nxt[2] = lb_r & tbi_mode;
        out_nxt[3] = spd_r & spd_writable;
        out_nxt[4] = an_r & an_present;
        out_nxt[5] = pd_r & pma_present & ~tbi_mode;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_r <= 6'h01;
        end else begin
            out_r <= out_nxt;
        end
    end

    assign core_reset        = out_r[0];
    assign loopback_internal = out_r[1];
    assign wrap_out          = out_r[2];
    assign speed_lsb         = out_r[3];
    assign an_enable         = out_r[4];
    assign power_down_xcvr   = out_r[5];

endmodule

// ==== core/pcr_control_register.sv ====
// Top of the PCS control register: management frame engine and bank
`timescale 1ns/1ps
module pcr_control_register (
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       ext_reset,
    input  wire logic       clock_manager_lock,
    input  wire logic       mdc,
    input  wire logic       mdio_i,
    output logic            mdio_o,
    output logic            mdio_t,
    input  wire logic [4:0] phy_addr,
    input  wire logic       tbi_mode,
    input  wire logic       sgmii_mode,
    input  wire logic       pgc_mode,
    input  wire logic       an_present,
    input  wire logic       on_chip_xcvr,
    input  wire logic       pma_present,
    input  wire logic       rx_client_clock_source,
    input  wire logic       cfg_load,
    input  wire logic [4:0] cfg_vector,
    output logic            core_reset,
    output logic            loopback_internal,
    output logic            wrap_out,
    output logic            speed_lsb,
    output logic            an_enable,
    output logic            power_down_xcvr
);

    typedef enum {
        PCR_PRE,
        PCR_START,
        PCR_HDR,
        PCR_TA,
        PCR_DATA
    } pcr_mdio_state_e;

    pcr_mgmt_if mgmt ();

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [4:0] sync1_r, sync1_nxt;
    logic [4:0] sync2_r, sync2_nxt;
    logic       mdc_d_r, mdc_d_nxt;
    logic       mdc_rise;
    logic       bit_in;

    // First stage feeds only the second; edge detect uses stages two and three
    always_comb begin
        sync1_nxt = {ext_reset, clock_manager_lock, 1'b0, mdio_i, mdc};
        sync2_nxt = sync1_r;
        mdc_d_nxt = sync2_r[0];
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
            mdc_d_r <= 1'b0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            mdc_d_r <= mdc_d_nxt;
        end
    end

    assign mdc_rise = sync2_r[0] & ~mdc_d_r;
    assign bit_in   = sync2_r[1];

    // ------------------------------------------------------------------
    // Management frame engine
    // ------------------------------------------------------------------
    pcr_mdio_state_e st_r, st_nxt;
    logic [4:0]      cnt_r, cnt_nxt;
    logic [15:0]     shf_r, shf_nxt;
    logic [15:0]     out_r, out_nxt;
    logic [4:0]      reg_r, reg_nxt;
    logic            ones_r, ones_nxt;
    logic            rd_r, rd_nxt;
    logic            wr_r, wr_nxt;
    logic            mdo_r, mdo_nxt;
    logic            mdt_r, mdt_nxt;
    logic [11:0]     hdr;
    logic            addressed;

    // Header as it stands once its last bit arrives
    assign hdr       = {shf_r[10:0], bit_in};
    assign addressed = (hdr[9:5] == phy_addr) || (hdr[9:5] == pcr_pkg::BCAST_PHY_ADDR);

    // Bits are taken on the rising clock edge; our drive changes just after it,
    // which leaves the master nearly a whole management clock of setup
    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        shf_nxt  = shf_r;
        out_nxt  = out_r;
        reg_nxt  = reg_r;
        ones_nxt = ones_r;
        rd_nxt   = rd_r;
        wr_nxt   = wr_r;
        mdo_nxt  = mdo_r;
        mdt_nxt  = mdt_r;
        if (mdc_rise) begin
            case (st_r)
                PCR_PRE: begin
                    if (bit_in) begin
                        ones_nxt = 1'b1;
                    end else if (ones_r) begin
                        st_nxt = PCR_START;
                    end
                end
                PCR_START: begin
                    ones_nxt = 1'b0;
                    cnt_nxt  = 5'h00;
                    st_nxt   = bit_in ? PCR_HDR : PCR_PRE;
                end
                PCR_HDR: begin
                    shf_nxt = {shf_r[14:0], bit_in};
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == pcr_pkg::HDR_LAST) begin
                        reg_nxt = hdr[4:0];
                        rd_nxt  = addressed && (hdr[11:10] == pcr_pkg::OP_READ);
                        wr_nxt  = addressed && (hdr[11:10] == pcr_pkg::OP_WRITE);
                        cnt_nxt = 5'h00;
                        st_nxt  = PCR_TA;
                    end
                end
                PCR_TA: begin
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == 5'h00) begin
                        // On a read addressed to us, take the line for the second turnaround bit
                        out_nxt = mgmt.rd_data;
                        mdo_nxt = 1'b0;
                        mdt_nxt = rd_r;
                    end else if (cnt_r == pcr_pkg::TA_LAST) begin
                        mdo_nxt = out_r[15];
                        out_nxt = {out_r[14:0], 1'b0};
                        cnt_nxt = 5'h00;
                        st_nxt  = PCR_DATA;
                    end
                end
                PCR_DATA: begin
                    shf_nxt = {shf_r[14:0], bit_in};
                    cnt_nxt = cnt_r + 5'h01;
                    mdo_nxt = out_r[15];
                    out_nxt = {out_r[14:0], 1'b0};
                    if (cnt_r == pcr_pkg::DATA_LAST) begin
                        // A fresh preamble is needed before the next frame
                        mdo_nxt = 1'b0;
                        mdt_nxt = 1'b0;
                        rd_nxt  = 1'b0;
                        wr_nxt  = 1'b0;
                        st_nxt  = PCR_PRE;
                    end
                end
                default: begin
                    st_nxt  = PCR_PRE;
                    mdt_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_r   <= PCR_PRE;
            cnt_r  <= 5'h00;
            shf_r  <= 16'h0000;
            out_r  <= 16'h0000;
            reg_r  <= 5'h00;
            ones_r <= 1'b0;
            rd_r   <= 1'b0;
            wr_r   <= 1'b0;
            mdo_r  <= 1'b0;
            mdt_r  <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            shf_r  <= shf_nxt;
            out_r  <= out_nxt;
            reg_r  <= reg_nxt;
            ones_r <= ones_nxt;
            rd_r   <= rd_nxt;
            wr_r   <= wr_nxt;
            mdo_r  <= mdo_nxt;
            mdt_r  <= mdt_nxt;
        end
    end

    // Strobes into the bank: write on the last data bit, read at turnaround
    assign mgmt.wr_stb   = mdc_rise && (st_r == PCR_DATA) && (cnt_r == pcr_pkg::DATA_LAST)
                           && wr_r;
    assign mgmt.rd_stb   = mdc_rise && (st_r == PCR_TA) && (cnt_r == 5'h00) && rd_r;
    assign mgmt.reg_addr = reg_r;
    assign mgmt.wr_data  = {shf_r[14:0], bit_in};

    assign mdio_o = mdo_r;
    assign mdio_t = mdt_r;

    // ------------------------------------------------------------------
    // Control register bank
    // ------------------------------------------------------------------
    pcr_ctrl_bank u_bank (
        .ref_clk                (ref_clk),
        .nrst                   (nrst),
        .mgmt                   (mgmt.bank),
        .ext_reset_sync         (sync2_r[4]),
        .lock_sync              (sync2_r[3]),
        .tbi_mode               (tbi_mode),
        .sgmii_mode             (sgmii_mode),
        .pgc_mode               (pgc_mode),
        .an_present             (an_present),
        .on_chip_xcvr           (on_chip_xcvr),
        .pma_present            (pma_present),
        .rx_client_clock_source (rx_client_clock_source),
        .cfg_load               (cfg_load),
        .cfg_vector             (cfg_vector),
        .core_reset             (core_reset),
        .loopback_internal      (loopback_internal),
        .wrap_out               (wrap_out),
        .speed_lsb              (speed_lsb),
        .an_enable              (an_enable),
        .power_down_xcvr        (power_down_xcvr)
    );

endmodule

// ==== bench/pcr_mdio_master.sv ====
// Station-management master model that frames management reads and writes
`timescale 1ns/1ps
module pcr_mdio_master (
    output logic      mdc,
    output wire logic mdio_i,
    input  wire logic mdio_o,
    input  wire logic mdio_t
);
    logic m_en;
    logic m_bit;

    // Shared wire: device when it drives, else master, else the pull-up level
    assign mdio_i = mdio_t ? mdio_o : (m_en ? m_bit : 1'b1);

    // Clock stands low outside frames
    initial begin
        mdc   = 1'b0;
        m_en  = 1'b0;
        m_bit = 1'b1;
    end

    // One bit: data set while clock is low, sampled by both sides on the rise
    task automatic clk_bit(input logic drv, input logic b, output logic smp);
        m_en  = drv;
        m_bit = b;
        #24;
        mdc = 1'b1;
        smp = mdio_i;
        #24;
        mdc = 1'b0;
    endtask

    // Preamble, start, op, address fields, turnaround, then data MSB first
    task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [45:0] hd;
        logic        s;
        logic        wr;
        hd = {32'hffffffff, 2'h1, op, phy, rg};
        wr = (op == pcr_pkg::OP_WRITE);
        for (int i = 45; i >= 0; i--)
            clk_bit(1'b1, hd[i], s);
        for (int i = 1; i >= 0; i--)
            clk_bit(wr, i[0], s);
        for (int i = 15; i >= 0; i--) begin
            clk_bit(wr, wd[i], s);
            rd[i] = s;
        end
        m_en = 1'b0;
    endtask
endmodule

// ==== bench/pcr_ctrl_checker_properties.sv ====
// Concurrent checks on the PCS control register ports
`timescale 1ns/1ps
module pcr_ctrl_checker (
    input wire logic       ref_clk,
    input wire logic       nrst,
    input wire logic       ext_reset,
    input wire logic       clock_manager_lock,
    input wire logic       mdc,
    input wire logic       mdio_o,
    input wire logic       mdio_t,
    input wire logic       tbi_mode,
    input wire logic       sgmii_mode,
    input wire logic       pgc_mode,
    input wire logic       an_present,
    input wire logic       on_chip_xcvr,
    input wire logic       pma_present,
    input wire logic       rx_client_clock_source,
    input wire logic       cfg_load,
    input wire logic [4:0] cfg_vector,
    input wire logic       core_reset,
    input wire logic       loopback_internal,
    input wire logic       wrap_out,
    input wire logic       speed_lsb,
    input wire logic       an_enable,
    input wire logic       power_down_xcvr
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    // Counts reset cycles with no outside cause; a soft reset that never ends shows here
    logic [3:0] rst_cnt_r;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            rst_cnt_r <= 4'h0;
        else if (!core_reset || ext_reset || !clock_manager_lock)
            rst_cnt_r <= 4'h0;
        else if (rst_cnt_r != 4'hf)
            rst_cnt_r <= rst_cnt_r + 4'h1;
    end

    // ----------------------------------------------------------------
    // Sequences and properties
    // ----------------------------------------------------------------
    sequence s_pd_drop;
        power_down_xcvr && pma_present && !tbi_mode
        ##1 !power_down_xcvr && $stable(pma_present) && $stable(tbi_mode);
    endsequence
    sequence s_cfg_lb;
        cfg_load && !core_reset && cfg_vector[3] && on_chip_xcvr && !tbi_mode
        && !rx_client_clock_source;
    endsequence

    property p_lb_gate;
        loopback_internal |-> $past(on_chip_xcvr) && !$past(tbi_mode)
                              && !$past(rx_client_clock_source);
    endproperty
    property p_wrap_gate;   wrap_out |-> $past(tbi_mode); endproperty
    property p_spd_gate;    speed_lsb |-> $past(sgmii_mode) && $past(pgc_mode); endproperty
    property p_an_gate;     an_enable |-> $past(an_present); endproperty
    property p_pd_gate;     power_down_xcvr |-> $past(pma_present) && !$past(tbi_mode); endproperty
    property p_pd_sticky;   s_pd_drop |-> ##[0:2] core_reset; endproperty
    property p_rst_defaults;
        core_reset [*3] |-> !loopback_internal && !wrap_out && !speed_lsb && !power_down_xcvr;
    endproperty
    property p_rst_sources; (ext_reset || !clock_manager_lock) [*5] |-> core_reset; endproperty
    property p_soft_len;    $rose(core_reset) |-> core_reset [*4]; endproperty
    property p_rst_bounded; rst_cnt_r <= 4'ha; endproperty
    property p_cfg_load;    s_cfg_lb |-> ##2 (loopback_internal || core_reset); endproperty
    property p_mdio_timing;
        $changed(mdio_o) || $changed(mdio_t) |-> $past(mdc, 1) && $past(mdc, 2);
    endproperty

    a_lb_gate:      assert property (p_lb_gate) else $error("loopback out of mode");
    a_wrap_gate:    assert property (p_wrap_gate) else $error("wrap out of mode");
    a_spd_gate:     assert property (p_spd_gate) else $error("speed bit out of mode");
    a_an_gate:      assert property (p_an_gate) else $error("negotiation out of mode");
    a_pd_gate:      assert property (p_pd_gate) else $error("power down out of mode");
    a_pd_sticky:    assert property (p_pd_sticky) else $error("power down cleared");
    a_rst_defaults: assert property (p_rst_defaults) else $error("not default in reset");
    a_rst_sources:  assert property (p_rst_sources) else $error("reset source ignored");
    a_soft_len:     assert property (p_soft_len) else $error("core reset too short");
    a_rst_bounded:  assert property (p_rst_bounded) else $error("reset never ends");
    a_cfg_load:     assert property (p_cfg_load) else $error("vector load lost");
    a_mdio_timing:  assert property (p_mdio_timing) else $error("data changed off clock");
endmodule

bind pcr_control_register pcr_ctrl_checker chk (.ref_clk, .nrst, .ext_reset,
    .clock_manager_lock, .mdc, .mdio_o, .mdio_t, .tbi_mode, .sgmii_mode, .pgc_mode,
    .an_present, .on_chip_xcvr, .pma_present, .rx_client_clock_source, .cfg_load,
    .cfg_vector, .core_reset, .loopback_internal, .wrap_out, .speed_lsb, .an_enable,
    .power_down_xcvr);

// ==== bench/pcr_control_register_tb.sv ====
// Self-checking testbench for the PCS control register
`timescale 1ns/1ps
module pcr_control_register_tb;
    logic ref_clk, nrst, ext_reset, clock_manager_lock, mdc, mdio_i, mdio_o, mdio_t;
    logic tbi_mode, sgmii_mode, pgc_mode, an_present, on_chip_xcvr, pma_present;
    logic rx_client_clock_source, cfg_load, core_reset, loopback_internal, wrap_out;
    logic speed_lsb, an_enable, power_down_xcvr, seen_rst;
    logic [4:0]  phy_addr;
    logic [4:0]  cfg_vector;
    logic [15:0] rd;
    int          failures;
    int          checks;
    wire  [5:0]  outs = {core_reset, loopback_internal, wrap_out, speed_lsb, an_enable,
                         power_down_xcvr};

    pcr_control_register uut (.ref_clk, .nrst, .ext_reset, .clock_manager_lock, .mdc,
        .mdio_i, .mdio_o, .mdio_t, .phy_addr, .tbi_mode, .sgmii_mode, .pgc_mode,
        .an_present, .on_chip_xcvr, .pma_present, .rx_client_clock_source, .cfg_load,
        .cfg_vector, .core_reset, .loopback_internal, .wrap_out, .speed_lsb, .an_enable,
        .power_down_xcvr);
    pcr_mdio_master mst (.mdc, .mdio_i, .mdio_o, .mdio_t);

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Write, then let the update reach the registered outputs
    task automatic wr(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                      input logic [15:0] d);
        logic [15:0] dummy;
        mst.xfer(op, phy, rg, d, dummy);
        repeat (8) @(posedge ref_clk);
        #1;
    endtask
    task automatic rdr(input logic [4:0] phy, input logic [4:0] rg);
        mst.xfer(pcr_pkg::OP_READ, phy, rg, 16'h0000, rd);
        @(posedge ref_clk);
        #1;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_fields;
        rdr(5'h03, 5'h00);
        check(rd, 16'h1000);
        check({10'h0, outs}, 16'h0002);
        wr(pcr_pkg::OP_WRITE, 5'h03, 5'h00, 16'h6000);
        check({10'h0, outs}, 16'h0014);
        wr(pcr_pkg::OP_WRITE, 5'h00, 5'h00, 16'h5000);  // Broadcast address is obeyed
        wr(pcr_pkg::OP_WRITE, 5'h07, 5'h00, 16'h0000);  // Foreign address ignored
        wr(pcr_pkg::OP_WRITE, 5'h03, 5'h01, 16'h0000);  // Other register dropped
        wr(2'h0, 5'h03, 5'h00, 16'h0000);
        wr(2'h3, 5'h03, 5'h00, 16'h0000);
        rdr(5'h03, 5'h00);
        check(rd, 16'h5000);
        rdr(5'h03, 5'h01);
        check(rd, 16'h0000);
        rdr(5'h07, 5'h00);
        check(rd, 16'hffff);
        $display("test fields done");
    endtask

    task automatic t_power;
        wr(pcr_pkg::OP_WRITE, 5'h03, 5'h00, 16'h1800);
        check({10'h0, outs}, 16'h0003);
        wr(pcr_pkg::OP_WRITE, 5'h03, 5'h00, 16'h1000);
        rdr(5'h03, 5'h00);
        check(rd, 16'h1800);
        seen_rst = 1'b0;
        wr(pcr_pkg::OP_WRITE, 5'h03, 5'h00, 16'h8000);
        check({15'h0, seen_rst}, 16'h0001);
        rdr(5'h03, 5'h00);
        check(rd, 16'h1000);
        check({10'h0, outs}, 16'h0002);
        $display("test power done");
    endtask

    task automatic t_modes;
        tbi_mode = 1'b1;
        wr(pcr_pkg::OP_WRITE, 5'h03, 5'h00, 16'h4800);
        check({10'h0, outs}, 16'h0008);
        rdr(5'h03, 5'h00);
        check(rd, 16'h4800);
        tbi_mode   = 1'b0;
        sgmii_mode = 1'b0;
        wr(pcr_pkg::OP_WRITE, 5'h03, 5'h00, 16'h8000);
        wr(pcr_pkg::OP_WRITE, 5'h03, 5'h00, 16'h2000);
        rdr(5'h03, 5'h00);
        check(rd, 16'h0000);
        sgmii_mode = 1'b1;
        pgc_mode   = 1'b0;
        wr(pcr_pkg::OP_WRITE, 5'h03, 5'h00, 16'h2000);
        check({10'h0, outs}, 16'h0000);
        pgc_mode               = 1'b1;
        rx_client_clock_source = 1'b1;
        wr(pcr_pkg::OP_WRITE, 5'h03, 5'h00, 16'h4000);
        check({10'h0, outs}, 16'h0000);
        rx_client_clock_source = 1'b0;
        // Options absent: stored bits must not reach the pins; of the read word only the negotiation bit is masked
        {an_present, on_chip_xcvr, pma_present} = 3'h0;
        wr(pcr_pkg::OP_WRITE, 5'h03, 5'h00, 16'h5800);
        check({10'h0, outs}, 16'h0000);
        rdr(5'h03, 5'h00);
        check(rd, 16'h4800);
        {an_present, on_chip_xcvr, pma_present} = 3'h7;
        wr(pcr_pkg::OP_WRITE, 5'h03, 5'h00, 16'h1000);
        $display("test modes done");
    endtask

    // Vector load, then each outside reset source restores the defaults
    task automatic t_cfg;
        cfg_vector = 5'h0b;
        cfg_load   = 1'b1;
        @(posedge ref_clk);
        #1;
        cfg_load = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        check({10'h0, outs}, 16'h0013);
        for (int k = 0; k < 2; k++) begin
            ext_reset          = (k == 0);
            clock_manager_lock = (k == 0);
            repeat (8) @(posedge ref_clk);
            #1;
            ext_reset          = 1'b0;
            clock_manager_lock = 1'b1;
            repeat (12) @(posedge ref_clk);
            #1;
            rdr(5'h03, 5'h00);
            check(rd, 16'h1000);
            wr(pcr_pkg::OP_WRITE, 5'h03, 5'h00, 16'h4000);
        end
        $display("test cfg done");
    endtask

    // ----------------------------------------------------------------
    // Clock, reset, sequence and hang guard
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
        if (core_reset === 1'b1)
            seen_rst <= 1'b1;
    initial begin
        #200000;
        failures++;
        finish_test();
    end
    initial begin
        failures = 0;
        checks = 0;
        {nrst, ext_reset, cfg_load, tbi_mode, rx_client_clock_source, seen_rst} = 6'h00;
        {clock_manager_lock, sgmii_mode, pgc_mode, an_present, on_chip_xcvr} = 5'h1f;
        pma_present = 1'b1;
        phy_addr    = 5'h03;
        cfg_vector  = 5'h00;
        repeat (3) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        repeat (10) @(posedge ref_clk);
        #1;
        t_fields();
        t_power();
        t_modes();
        t_cfg();
        finish_test();
    end
endmodule
